// *** src/svlfc_pkg.sv ***
package svlfc_pkg;
  // Clock and loop sample rate.
  localparam int CLK_HZ = 40_000_000;
  localparam int SAMPLE_HZ = 2048;
  localparam int SMP_DIV = CLK_HZ / SAMPLE_HZ;
  localparam int OUT_SHIFT_DEF = 8;
  localparam int ADR_W = 18;
  // Register word indices; the byte address is four times the index.
  localparam logic [15:0] IDX_STATE = 16'h37DD;
  localparam logic [15:0] IDX_VFF = 16'h38A5;
  localparam logic [15:0] IDX_AFF = 16'h39D1;
  localparam logic [15:0] IDX_LAW = 16'h4269;
  localparam logic [15:0] IDX_SPEED = 16'h0000;
  localparam logic [15:0] IDX_ACCEL = 16'h0001;
  localparam logic [15:0] IDX_GAINS = 16'h0002;
  localparam logic [15:0] IDX_BAND = 16'h0003;
  localparam logic [15:0] IDX_DECEL = 16'h0004;
  localparam logic [15:0] IDX_TARGET = 16'h0005;
  localparam logic [15:0] IDX_CMD = 16'h0006;
  localparam logic [15:0] IDX_FAULT = 16'h0007;
  localparam logic [15:0] IDX_ENC = 16'h0008;
  localparam logic [15:0] IDX_ERR = 16'h0009;
  // Command word bits.
  localparam int CMD_PROF = 0;
  localparam int CMD_MOVE = 1;
  localparam int CMD_STOP = 2;
  localparam int M_SPEED = 8;
  localparam int M_ACCEL = 9;
  localparam int M_GAINS = 10;
  // Fixed-point layout of speed and position.
  localparam int SPD_FRAC = 11;
  localparam int POS_FRAC = 22;
  localparam logic [34:0] SPD_FLOOR = 35'h0000_0800;
  localparam logic [7:0] P_MIN = 8'h01;
  // Loop law selection values.
  typedef enum logic [2:0] {
    LAW_PID = 3'h0,
    LAW_DIR_NEG = 3'h1,
    LAW_DIR_POS = 3'h2,
    LAW_FF = 3'h5
  } svlfc_law_t;
  typedef enum logic [1:0] {
    HOLD_AT = 2'h0,
    HOLD_BAND = 2'h1,
    HOLD_OFF = 2'h2
  } svlfc_hold_t;
  typedef enum logic [1:0] {
    MS_IDLE = 2'h0,
    MS_ACCEL = 2'h1,
    MS_CRUISE = 2'h2,
    MS_DECEL = 2'h3
  } svlfc_ms_t;
  // Motion profile parameter set.
  typedef struct packed {
    logic [1:0] hold;
    logic [7:0] d;
    logic [7:0] i;
    logic [7:0] p;
    logic [23:0] decel;
    logic [23:0] accel;
    logic [23:0] speed;
  } svlfc_prof_t;
  localparam svlfc_prof_t PROF_RST = '{hold: 2'h0, d: 8'h00, i: 8'h00, p: 8'h01,
    decel: 24'h0, accel: 24'h0, speed: 24'h0};
  // Quadrature encoder pins.
  typedef struct packed {
    logic a;
    logic b;
  } svlfc_enc_t;
endpackage

// *** src/svlfc_top.sv ***
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module svlfc_top import svlfc_pkg::*; #(
  parameter int SAMPLE_DIV = SMP_DIV,
  parameter int OUT_SHIFT = OUT_SHIFT_DEF
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Servo drive side.
  input wire svlfc_enc_t enc_i,
  output logic signed [15:0] dac_o,
  output logic drive_en_o
);
  if (SAMPLE_DIV < 2 || OUT_SHIFT < 0 || OUT_SHIFT > 40) begin : g_chk
    $error("svlfc_top: unsupported parameter value");
  end

  // Sample-rate divider giving a one-cycle tick.
  logic [31:0] div_q;
  logic tick_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 32'h0;
      tick_q <= 1'b0;
    end else if (div_q == 32'(SAMPLE_DIV - 1)) begin
      div_q <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  // Encoder pins pass two flops before the decoder looks at them.
  // They run through reset so that no stale level is left behind.
  logic [1:0] s1_q, s2_q, prv_q;
  logic signed [31:0] enc_pos_q;
  always_ff @(posedge clk_i) begin
    s1_q <= {enc_i.a, enc_i.b};
    s2_q <= s1_q;
  end

  // Quadrature x4 counting; a double transition is dropped as noise.
  // The previous level tracks the pins in reset, else a parked shaft reads as an edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prv_q <= s2_q;
      enc_pos_q <= 32'sh0;
    end else begin
      prv_q <= s2_q;
      if (s2_q != prv_q && s2_q != ~prv_q) begin
        enc_pos_q <= (s2_q[1] ^ prv_q[0]) ? enc_pos_q + 32'sh1 : enc_pos_q - 32'sh1;
      end
    end
  end

  // Bus decode; the slave answers one cycle after the strobe.
  logic ack_q, req, wr;
  logic [15:0] idx;
  logic [31:0] rd_w, wv, dat_q;
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  assign idx = wb_adr_i[ADR_W-1:2];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Byte lanes not selected keep the register's present contents.
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++) begin
      if (s[k]) begin
        r[8*k +: 8] = n[8*k +: 8];
      end
    end
    return r;
  endfunction
  assign wv = wmerge(rd_w, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req;
      dat_q <= req ? rd_w : 32'h0;
    end
  end

  // Software registers and command strobes.
  logic [31:0] vff_q, aff_q, law_sel_q, band_q;
  logic signed [31:0] tgt_q;
  svlfc_prof_t stg_q, act_q;
  logic prof_go, move_go, stop_go;
  assign prof_go = wr && idx == IDX_CMD && wv[CMD_PROF];
  assign move_go = wr && idx == IDX_CMD && wv[CMD_MOVE];
  assign stop_go = wr && idx == IDX_CMD && wv[CMD_STOP];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vff_q <= 32'h0;
      aff_q <= 32'h0;
      law_sel_q <= 32'h0;
      band_q <= 32'h0;
      tgt_q <= 32'sh0;
      stg_q <= PROF_RST;
    end else if (wr) begin
      case (idx)
        IDX_VFF: vff_q <= wv;
        IDX_AFF: aff_q <= wv;
        IDX_LAW: law_sel_q <= wv;
        IDX_BAND: band_q <= wv;
        IDX_TARGET: tgt_q <= wv;
        IDX_SPEED: stg_q.speed <= wv[23:0];
        IDX_ACCEL: stg_q.accel <= wv[23:0];
        IDX_GAINS: begin
          stg_q.p <= (wv[7:0] == 8'h00) ? P_MIN : wv[7:0];
          stg_q.i <= wv[15:8];
          stg_q.d <= wv[23:16];
          stg_q.hold <= wv[25:24];
        end
        default: begin
        end
      endcase
    end
  end

  // Profile execution into the active set.
  logic profiled_q;
  svlfc_law_t law_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_q <= PROF_RST;
      profiled_q <= 1'b0;
      law_q <= LAW_PID;
    end else if (prof_go) begin
      if (!profiled_q || wv[M_SPEED]) begin
        act_q.speed <= stg_q.speed;
      end
      if (!profiled_q || wv[M_ACCEL]) begin
        act_q.accel <= stg_q.accel;
        act_q.decel <= stg_q.accel;
      end
      if (!profiled_q || wv[M_GAINS]) begin
        act_q.p <= stg_q.p;
        act_q.i <= stg_q.i;
        act_q.d <= stg_q.d;
        act_q.hold <= stg_q.hold;
      end
      profiled_q <= 1'b1;
      if (!profiled_q) begin
        case (law_sel_q)
          32'h0000_0001: law_q <= LAW_DIR_NEG;
          32'h0000_0002: law_q <= LAW_DIR_POS;
          32'h0000_0005: law_q <= LAW_FF;
          default: law_q <= LAW_PID;
        endcase
      end
    end else if (wr && idx == IDX_DECEL) begin
      act_q.decel <= wv[23:0];
    end
  end

  // Not-ready fault: a new event wins over a clear in the same cycle.
  logic fault_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= 1'b0;
    end else if (move_go && !profiled_q) begin
      fault_q <= 1'b1;
    end else if (wr && idx == IDX_FAULT && wb_sel_i[0] && wb_dat_i[0]) begin
      fault_q <= 1'b0;
    end
  end

  // Trapezoidal profile helpers; speed is steps/s scaled by 2048.
  logic [53:0] pos_q;
  logic [34:0] spd_q, spd_n, vmax, acc35, dec35;
  logic signed [31:0] goal_q, pos_int, rem, err_w;
  logic [23:0] spd_int;
  logic [56:0] bd_l;
  logic [47:0] bd_r;
  logic moving_q, dir_q, brake, done;
  svlfc_ms_t ms_q, ms_n;
  assign pos_int = pos_q[53:POS_FRAC];
  assign rem = dir_q ? pos_int - goal_q : goal_q - pos_int;
  assign spd_int = spd_q[34:SPD_FRAC];
  assign vmax = {act_q.speed, 11'h000};
  assign acc35 = {11'h000, act_q.accel};
  assign dec35 = {11'h000, act_q.decel};
  assign bd_l = {rem, 1'b0} * act_q.decel;
  assign bd_r = spd_int * spd_int;
  // Brake once the remaining distance is within v*v/(2*decel).
  assign brake = rem <= 32'sh0 || bd_l <= {9'h000, bd_r};
  assign done = rem <= 32'sh0 || {rem[31:0], 22'h0} <= {19'h0, spd_n};

  always_comb begin
    spd_n = spd_q;
    ms_n = MS_CRUISE;
    if (brake) begin
      spd_n = (spd_q > dec35 + SPD_FLOOR) ? spd_q - dec35 : SPD_FLOOR;
      ms_n = MS_DECEL;
    end else if (spd_q < vmax) begin
      spd_n = (vmax - spd_q > acc35) ? spd_q + acc35 : vmax;
      ms_n = MS_ACCEL;
    end else if (spd_q > vmax) begin
      spd_n = (spd_q - vmax > dec35) ? spd_q - dec35 : vmax;
      ms_n = MS_DECEL;
    end
  end

  // Motion generator stepping once per sample tick.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_q <= 54'h0;
      spd_q <= 35'h0;
      goal_q <= 32'sh0;
      moving_q <= 1'b0;
      dir_q <= 1'b0;
      ms_q <= MS_IDLE;
    end else if (stop_go) begin
      spd_q <= 35'h0;
      moving_q <= 1'b0;
      goal_q <= pos_int;
      ms_q <= MS_IDLE;
    end else if (move_go && profiled_q) begin
      goal_q <= tgt_q;
      dir_q <= tgt_q < pos_int;
      moving_q <= 1'b1;
      ms_q <= MS_ACCEL;
    end else if (tick_q && moving_q) begin
      if (done) begin
        pos_q <= {goal_q, 22'h0};
        spd_q <= 35'h0;
        moving_q <= 1'b0;
        ms_q <= MS_IDLE;
      end else begin
        pos_q <= dir_q ? pos_q - {19'h0, spd_n} : pos_q + {19'h0, spd_n};
        spd_q <= spd_n;
        ms_q <= ms_n;
      end
    end
  end

  // Loop law arithmetic.
  logic signed [31:0] last_q, acc_q, abs_e;
  logic signed [32:0] de, acc_s;
  logic signed [24:0] vel_s, vlast_q;
  logic signed [25:0] dv;
  logic signed [47:0] pid_sum, ff_sum, scl;
  logic signed [15:0] sat, dac_n;
  logic quiet, acc_ovf;
  assign err_w = pos_int - enc_pos_q;
  assign de = {err_w[31], err_w} - {last_q[31], last_q};
  assign vel_s = dir_q ? -$signed({1'b0, spd_int}) : $signed({1'b0, spd_int});
  assign dv = {vel_s[24], vel_s} - {vlast_q[24], vlast_q};
  assign abs_e = err_w[31] ? -err_w : err_w;
  assign pid_sum = err_w * $signed({1'b0, act_q.p}) + de * $signed({1'b0, act_q.d})
                 + acc_q * $signed({1'b0, act_q.i});
  assign ff_sum = err_w * $signed({1'b0, act_q.p}) + dv * $signed(aff_q[15:0])
                + vel_s * $signed(vff_q[15:0]);
  assign scl = ((law_q == LAW_FF) ? ff_sum : pid_sum) >>> OUT_SHIFT;
  assign sat = (scl > 48'sh7FFF) ? 16'sh7FFF :
               (scl < 48'shFFFF_FFFF_8001) ? 16'sh8001 : scl[15:0];
  assign quiet = !profiled_q || (!moving_q && (act_q.hold == HOLD_OFF ||
                 (act_q.hold == HOLD_BAND && $unsigned(abs_e) <= band_q)));
  assign acc_s = {acc_q[31], acc_q} + {err_w[31], err_w};
  assign acc_ovf = acc_s[32] != acc_s[31];

  always_comb begin
    dac_n = 16'sh0;
    if (profiled_q && law_q == LAW_DIR_POS) begin
      dac_n = $signed({1'b0, vff_q[14:0]});
    end else if (profiled_q && law_q == LAW_DIR_NEG) begin
      dac_n = -$signed({1'b0, vff_q[14:0]});
    end else if (!quiet) begin
      dac_n = sat;
    end
  end

  // Loop state updated once per tick.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dac_o <= 16'sh0;
      last_q <= 32'sh0;
      acc_q <= 32'sh0;
      vlast_q <= 25'sh0;
      drive_en_o <= 1'b0;
    end else begin
      drive_en_o <= profiled_q;
      if (tick_q) begin
        dac_o <= dac_n;
        last_q <= err_w;
        vlast_q <= vel_s;
        if (law_q == LAW_PID && !quiet) begin
          acc_q <= acc_ovf ? (acc_s[32] ? 32'sh8000_0000 : 32'sh7FFF_FFFF) : acc_s[31:0];
        end
      end
    end
  end

  // Register read multiplexer.
  always_comb begin
    rd_w = 32'h0;
    case (idx)
      IDX_STATE: rd_w = {24'h0, law_q, fault_q, profiled_q, moving_q, ms_q};
      IDX_VFF: rd_w = vff_q;
      IDX_AFF: rd_w = aff_q;
      IDX_LAW: rd_w = law_sel_q;
      IDX_SPEED: rd_w = {8'h0, stg_q.speed};
      IDX_ACCEL: rd_w = {8'h0, stg_q.accel};
      IDX_GAINS: rd_w = {6'h0, stg_q.hold, stg_q.d, stg_q.i, stg_q.p};
      IDX_BAND: rd_w = band_q;
      IDX_DECEL: rd_w = {8'h0, act_q.decel};
      IDX_TARGET: rd_w = tgt_q;
      IDX_FAULT: rd_w = {31'h0, fault_q};
      IDX_ENC: rd_w = enc_pos_q;
      IDX_ERR: rd_w = err_w;
      default: rd_w = 32'h0;
    endcase
  end

  // Checks; the gap counter measures cycles between ticks.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [31:0] gap_q;
  logic seen_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || tick_q) begin
      gap_q <= 32'h0;
      seen_q <= !rst_i;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end
  sequence s_refused;
    move_go && !profiled_q ##1 fault_q && !moving_q;
  endsequence
  sequence s_pid_tick;
    tick_q && law_q == LAW_PID && !quiet && !acc_ovf;
  endsequence

  AST_SAMPLE_GAP: assert property (tick_q && seen_q |-> gap_q == 32'(SAMPLE_DIV - 1))
    else $error("sample tick spacing wrong");
  AST_ERR_LATCH: assert property (tick_q |=> last_q == $past(pos_int) - $past(enc_pos_q))
    else $error("previous error not latched");
  AST_LAW_OUT: assert property (tick_q && !quiet && law_q inside {LAW_PID, LAW_FF} &&
    scl <= 48'sh7FFF && scl >= 48'shFFFF_FFFF_8001 |=> dac_o == $past(scl[15:0]))
    else $error("loop output mismatch");
  AST_ACC_ADD: assert property (s_pid_tick |=> acc_q == $past(acc_q) + $past(err_w))
    else $error("accumulator did not add error");
  AST_CLAMP: assert property (tick_q && !quiet && law_q == LAW_PID && scl > 48'sh7FFF
    |=> dac_o == 16'sh7FFF ##1 dac_o != 16'sh8000)
    else $error("output not clamped");
  AST_CLAMP_NEG: assert property (tick_q && !quiet && law_q == LAW_PID &&
    scl < 48'shFFFF_FFFF_8001 |=> dac_o == 16'sh8001)
    else $error("negative output not clamped");
  AST_FF_NO_I: assert property (tick_q && law_q == LAW_FF |=> $stable(acc_q))
    else $error("integral moved in feedforward law");
  AST_DIRECT_POS: assert property (tick_q && profiled_q && law_q == LAW_DIR_POS
    |=> dac_o == $signed({1'b0, $past(vff_q[14:0])}))
    else $error("direct output wrong");
  AST_DIRECT_NEG: assert property (tick_q && profiled_q && law_q == LAW_DIR_NEG
    |=> dac_o <= 16'sh0)
    else $error("direct negative output positive");
  AST_NOT_READY: assert property (move_go && !profiled_q |-> s_refused)
    else $error("unprofiled move not refused");
  AST_OFF_HOLD: assert property (tick_q && profiled_q && !moving_q &&
    act_q.hold == HOLD_OFF && law_q == LAW_PID |=> dac_o == 16'sh0)
    else $error("off hold still drives");
  AST_DECEL_SAME: assert property (prof_go && wv[M_ACCEL] |=> act_q.decel == act_q.accel)
    else $error("decel not set from accel");
  AST_P_MIN: assert property (stg_q.p != 8'h00 && act_q.p != 8'h00)
    else $error("proportional gain zero");
endmodule
`default_nettype wire

// *** verification/svlfc_drive_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Servo drive with encoder; the bench pushes the shaft one edge at a time.
module svlfc_drive_model import svlfc_pkg::*; (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Shaft motion requests from the bench.
  input wire logic step_up_i,
  input wire logic step_dn_i,
  // Quadrature pins.
  output var svlfc_enc_t enc_o
);
  logic [1:0] ph_q;
  // Reset only clears an unknown phase; a known one survives, as a real shaft does.
  always_ff @(posedge clk_i) begin
    if (rst_i && $isunknown(ph_q)) begin
      ph_q <= 2'h0;
    end else if (step_up_i) begin
      ph_q <= ph_q + 2'h1;
    end else if (step_dn_i) begin
      ph_q <= ph_q - 2'h1;
    end
  end
  // Gray order 00,10,11,01 lets pin a lead when counting up.
  always_comb begin
    enc_o.a = ph_q[1] ^ ph_q[0];
    enc_o.b = ph_q[1];
  end
endmodule
`default_nettype wire

// *** verification/test_svlfc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_svlfc_top import svlfc_pkg::*;;
  localparam int DIV = 20;
  typedef struct packed {
    logic [15:0] idx;
    logic [31:0] wd;
    logic [31:0] rv;
    logic [31:0] rd;
  } svlfc_row_t;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, drive_en, step_up, step_dn;
  logic [ADR_W-1:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic signed [15:0] dac, v1, v2;
  svlfc_enc_t enc;
  int error_cnt, cmp_count, cyc_n, t1, t2;
  // Reset value, write, read back; read-only and unmapped places read fixed values.
  svlfc_row_t rows[9] = '{
    '{IDX_STATE, 32'hFFFF_FFFF, 32'h0, 32'h0}, '{IDX_VFF, 32'h7FFF, 32'h0, 32'h7FFF},
    '{IDX_AFF, 32'h1234, 32'h0, 32'h1234}, '{IDX_LAW, 32'h5, 32'h0, 32'h5},
    '{IDX_SPEED, 32'hAB_CDEF, 32'h0, 32'hAB_CDEF}, '{IDX_GAINS, 32'h0, 32'h1, 32'h1},
    '{IDX_BAND, 32'h5, 32'h0, 32'h5}, '{16'h0100, 32'hDEAD_BEEF, 32'h0, 32'h0},
    '{IDX_LAW, 32'h0, 32'h5, 32'h0}};
  int dl_law[3] = '{1, 2, 2};
  int dl_vff[3] = '{32767, 1000, 0};
  int dl_exp[3] = '{-32767, 1000, 0};

  svlfc_top #(.SAMPLE_DIV(DIV), .OUT_SHIFT(0)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .enc_i(enc), .dac_o(dac), .drive_en_o(drive_en));
  svlfc_drive_model i_drive (.clk_i(clk_i), .rst_i(rst_i), .step_up_i(step_up),
    .step_dn_i(step_dn), .enc_o(enc));

  // A 25 ns clock and a cycle count for timing the sample ticks.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc_n <= cyc_n + 1;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic w, input logic [15:0] idx, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= {idx, 2'b00};
    wb_dat_w <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      $display("mismatch at %0t: no bus answer", $time);
    end
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, idx, 32'h0, q);
    check(q & m, e, "register read");
  endtask
  // Pushing the shaft by n edges; spacing leaves room for the pin synchroniser.
  task automatic push(input int n);
    repeat (n) begin
      @(posedge clk_i);
      step_up <= 1'b1;
      @(posedge clk_i);
      step_up <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n * DIV + 4) @(posedge clk_i);
  endtask
  task automatic wait_chg(output logic signed [15:0] v, output int t);
    logic signed [15:0] p;
    int n;
    p = dac;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (dac === p && n < 3 * DIV);
    if (dac === p) begin
      error_cnt++;
      $display("mismatch at %0t: command output did not change", $time);
    end
    v = dac;
    t = cyc_n;
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic profile(input logic [31:0] gains);
    wr(IDX_SPEED, 32'd1000);
    wr(IDX_ACCEL, 32'd100);
    wr(IDX_GAINS, gains);
    wr(IDX_CMD, 32'h1);
  endtask

  // Main sequence: table first, then the hand-written cases.
  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, step_up, step_dn} = 6'h20;
    {wb_adr, wb_dat_w, cyc_n, error_cnt, cmp_count} = '0;
    wb_sel = 4'hF;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check(32'(dac), 0, "dac after reset");
    check(32'(drive_en), 0, "drive enable after reset");
    foreach (rows[k]) begin
      rdc(rows[k].idx, 32'hFFFF_FFFF, rows[k].rv);
      wr(rows[k].idx, rows[k].wd);
      rdc(rows[k].idx, 32'hFFFF_FFFF, rows[k].rd);
    end
    $display("test register table done");
    wr(IDX_CMD, 32'h2);
    rdc(IDX_FAULT, 32'h1, 32'h1);
    rdc(IDX_STATE, 32'h4, 32'h0);
    wr(IDX_FAULT, 32'h1);
    rdc(IDX_FAULT, 32'h1, 32'h0);
    profile(32'h0000_0002);
    rdc(IDX_STATE, 32'hFC, 32'h08);
    check(32'(drive_en), 1, "drive enable");
    push(3);
    ticks(2);
    rdc(IDX_ERR, 32'hFFFF_FFFF, 32'hFFFF_FFFD);
    check(32'(dac), -6, "proportional term");
    wr(IDX_GAINS, 32'h0100_0002);
    wr(IDX_CMD, 32'h401);
    ticks(2);
    check(32'(dac), 0, "inside deadband");
    push(3);
    ticks(2);
    check(32'(dac), -12, "outside deadband");
    wr(IDX_GAINS, 32'h0200_0002);
    wr(IDX_CMD, 32'h401);
    ticks(2);
    check(32'(dac), 0, "off at position");
    wr(IDX_GAINS, 32'h0000_0101);
    wr(IDX_CMD, 32'h401);
    wait_chg(v1, t1);
    wait_chg(v1, t1);
    wait_chg(v2, t2);
    check(32'(v2 - v1), -6, "integral step");
    check(32'(t2 - t1), DIV, "sample spacing");
    wr(IDX_GAINS, 32'h0000_00FF);
    wr(IDX_CMD, 32'h401);
    push(125);
    ticks(2);
    check(32'(dac), -32767, "clamped output");
    wr(IDX_GAINS, 32'h0001_0001);
    wr(IDX_CMD, 32'h401);
    ticks(3);
    v1 = dac;
    push(1);
    // A tick may fall inside the push; then the new command is already out.
    if (dac === v1) begin
      wait_chg(v1, t1);
    end else begin
      v1 = dac;
    end
    check(32'(v1), -133, "derivative term");
    wait_chg(v1, t1);
    check(32'(v1), -132, "derivative settles");
    $display("test default law done");
    do_reset();
    wr(IDX_LAW, 32'h5);
    profile(32'h00FF_FF02);
    wr(IDX_LAW, 32'h0);
    rdc(IDX_STATE, 32'hE0, 32'hA0);
    push(3);
    ticks(2);
    check(32'(dac), -6, "feedforward at rest");
    ticks(2);
    check(32'(dac), -6, "no integral build");
    wr(IDX_ACCEL, 32'd300);
    wr(IDX_CMD, 32'h201);
    rdc(IDX_DECEL, 32'hFF_FFFF, 32'd300);
    wr(IDX_DECEL, 32'd20);
    rdc(IDX_DECEL, 32'hFF_FFFF, 32'd20);
    wr(IDX_TARGET, 32'd400);
    wr(IDX_CMD, 32'h2);
    ticks(2);
    rdc(IDX_STATE, 32'h4, 32'h4);
    wr(IDX_CMD, 32'h4);
    ticks(1);
    rdc(IDX_STATE, 32'h4, 32'h0);
    $display("test feedforward law done");
    foreach (dl_law[k]) begin
      do_reset();
      wr(IDX_LAW, dl_law[k]);
      wr(IDX_VFF, dl_vff[k]);
      ticks(2);
      check(32'(dac), 0, "direct before profile");
      profile(32'h0000_0002);
      ticks(2);
      check(32'(dac), dl_exp[k], "direct output");
    end
    $display("test direct mode done");
    give_verdict();
  end

  // Watchdog sized well above the expected run of about 2500 cycles.
  initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
